// ---- rtl/pacd_regs.sv ----
// Register bank: medium attachment control, cable diagnostic results, scan state.
// Assumes an APB master on pclk and diagnostic results driven on the same clock.
`timescale 1ns/1ps

module pacd_regs #(
  parameter int RESET_CYCLES = pacd_pkg::ATT_RESET_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pacd_pkg::ADDR_W-1:0] paddr,
  input wire logic [pacd_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pacd_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pacd_pkg::METRIC_W-1:0] diag_metric,
  input wire logic diag_done,
  input wire logic [pacd_pkg::CABLE_LEN_W-1:0] diag_cable_len,
  output logic medium_attachment_reset,
  output logic medium_attachment_low_power,
  output logic medium_attachment_loopback,
  output logic fuse_supply_switch_en
);
  import pacd_pkg::*;

  // Decoded word indices as seen on the bus
  localparam logic [IDX_W-1:0] A_METRIC = IDX_W'(IDX_DIAG_METRIC);
  localparam logic [IDX_W-1:0] A_STATE = IDX_W'(IDX_DIAG_STATE);
  localparam logic [IDX_W-1:0] A_KEY = IDX_W'(IDX_FUSE_KEY);
  localparam logic [IDX_W-1:0] A_SCAN = IDX_W'(IDX_SCAN_STATE);
  localparam logic [IDX_W-1:0] A_CTRL1 = IDX_W'(IDX_ATT_CTRL1 & IDX_PREFIX_MASK);
  localparam logic [IDX_W-1:0] A_TYPE = IDX_W'(IDX_ATT_TYPE & IDX_PREFIX_MASK);

  logic [IDX_W-1:0] word_idx;
  logic word_aligned;
  logic setup_phase;
  logic access_done;
  logic wr_take;
  logic hit_metric;
  logic hit_state;
  logic hit_key;
  logic hit_scan;
  logic hit_ctrl1;
  logic hit_type;
  logic mapped;
  logic [REG_W-1:0] rd_word;
  logic [REG_W-1:0] wdata16;
  logic key_wr;
  logic att_reset_start;

  logic [METRIC_W-1:0] diag_metric_r;
  logic diag_done_r;
  logic [CABLE_LEN_W-1:0] diag_cable_len_r;
  logic low_power_r;
  logic loopback_r;
  logic att_reset_busy;
  logic fuse_switch;
  logic [DATA_W-1:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic low_power_out_r;
  logic loopback_out_r;

  assign word_idx = paddr[ADDR_W-1:2];
  assign word_aligned = (paddr[1:0] == 2'b00);
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable && pready_r;
  assign wr_take = access_done && pwrite && !pslverr_r;
  assign wdata16 = pwdata[REG_W-1:0];

  assign hit_metric = word_aligned && word_idx == A_METRIC;
  assign hit_state = word_aligned && word_idx == A_STATE;
  assign hit_key = word_aligned && word_idx == A_KEY;
  assign hit_scan = word_aligned && word_idx == A_SCAN;
  assign hit_ctrl1 = word_aligned && word_idx == A_CTRL1;
  assign hit_type = word_aligned && word_idx == A_TYPE;
  assign mapped = hit_metric || hit_state || hit_key || hit_scan || hit_ctrl1 || hit_type;

  // Key must arrive as one full low half-word; a partial write cannot unlock
  assign key_wr = wr_take && hit_key && pstrb[1:0] == 2'b11;
  assign att_reset_start = wr_take && hit_ctrl1 && pstrb[1] && wdata16[ATT_RESET_BIT];

  // Diagnostic results are sampled every cycle so a read sees one coherent snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_metric_r <= RST_DIAG_METRIC[METRIC_LSB +: METRIC_W];
      diag_done_r <= RST_DIAG_STATE[DIAG_DONE_BIT];
      diag_cable_len_r <= RST_DIAG_STATE[CABLE_LEN_W-1:0];
    end else begin
      diag_metric_r <= diag_metric;
      diag_done_r <= diag_done;
      diag_cable_len_r <= diag_cable_len;
    end
  end

  // Low-power setting, written through byte lane 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_r <= RST_ATT_CTRL1[LOW_POWER_BIT];
    end else if (wr_take && hit_ctrl1 && pstrb[1]) begin
      low_power_r <= wdata16[LOW_POWER_BIT];
    end
  end

  // Loopback setting, written through byte lane 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loopback_r <= RST_ATT_CTRL1[LOOPBACK_BIT];
    end else if (wr_take && hit_ctrl1 && pstrb[0]) begin
      loopback_r <= wdata16[LOOPBACK_BIT];
    end
  end

  pacd_reset_pulse #(
    .CYCLES(RESET_CYCLES)
  ) u_att_reset (
    .pclk(pclk),
    .presetn(presetn),
    .start(att_reset_start),
    .busy_r(att_reset_busy)
  );

  pacd_fuse_unlock u_fuse (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(key_wr),
    .wr_data(wdata16),
    .switch_r(fuse_switch)
  );

  // Read mux; every bit not named below stays zero
  always_comb begin
    rd_word = '0;
    if (hit_metric) begin
      rd_word[METRIC_LSB +: METRIC_W] = diag_metric_r;
    end else if (hit_state) begin
      rd_word[DIAG_DONE_BIT] = diag_done_r;
      rd_word[CABLE_LEN_W-1:0] = diag_cable_len_r;
    end else if (hit_scan) begin
      rd_word[SCAN_STATE_LSB +: SCAN_STATE_W] = RST_SCAN_STATE[SCAN_STATE_LSB +: SCAN_STATE_W];
      rd_word[FUSE_SW_BIT] = fuse_switch;
    end else if (hit_ctrl1) begin
      rd_word[ATT_RESET_BIT] = att_reset_busy;
      rd_word[LOW_POWER_BIT] = low_power_r;
      rd_word[LOOPBACK_BIT] = loopback_r;
    end else if (hit_type) begin
      rd_word[TYPE_SEL_W-1:0] = TYPE_SEL_CODE;
    end else begin
      rd_word = '0;
    end
  end

  // One wait-free access phase: the answer is prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= setup_phase;
    end
  end

  // Unmapped or misaligned words answer with an error and change nothing;
  // the flag stands only in the access cycle, alongside pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= setup_phase && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata_r <= {{(DATA_W-REG_W){1'b0}}, rd_word};
    end else if (access_done) begin
      prdata_r <= '0;
    end
  end

  // Settings leave through their own flops so the outputs stay glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_out_r <= RST_ATT_CTRL1[LOW_POWER_BIT];
      loopback_out_r <= RST_ATT_CTRL1[LOOPBACK_BIT];
    end else begin
      low_power_out_r <= low_power_r;
      loopback_out_r <= loopback_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign medium_attachment_reset = att_reset_busy;
  assign medium_attachment_low_power = low_power_out_r;
  assign medium_attachment_loopback = loopback_out_r;
  assign fuse_supply_switch_en = fuse_switch;

endmodule : pacd_regs

// ---- rtl/pacd_pkg.sv ----
// Constants for the medium attachment control and cable diagnostic register bank.
// Assumes a 100 MHz register clock and an APB slave with 32-bit data.
package pacd_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = 14;

  // Printed register indices; the byte address is four times the index with its leading nibble dropped
  localparam logic [15:0] IDX_DIAG_METRIC = 16'h0a9d;
  localparam logic [15:0] IDX_DIAG_STATE = 16'h0a9f;
  localparam logic [15:0] IDX_FUSE_KEY = 16'h0e00;
  localparam logic [15:0] IDX_SCAN_STATE = 16'h0e01;
  localparam logic [15:0] IDX_ATT_CTRL1 = 16'h1000;
  localparam logic [15:0] IDX_ATT_TYPE = 16'h1007;
  // Leading nibble only tells the attachment registers apart in listings
  localparam logic [15:0] IDX_PREFIX_MASK = 16'h0fff;

  // Reset values
  localparam logic [15:0] RST_DIAG_METRIC = 16'h0000;
  localparam logic [15:0] RST_DIAG_STATE = 16'h0000;
  localparam logic [15:0] RST_SCAN_STATE = 16'h0010;
  localparam logic [15:0] RST_ATT_CTRL1 = 16'h0000;
  localparam logic [15:0] RST_ATT_TYPE = 16'h003d;

  // Field layout
  localparam int METRIC_LSB = 4;
  localparam int METRIC_W = 12;
  localparam int DIAG_DONE_BIT = 15;
  localparam int CABLE_LEN_W = 11;
  localparam int FUSE_SW_BIT = 3;
  localparam int SCAN_STATE_LSB = 4;
  localparam int SCAN_STATE_W = 5;
  localparam int ATT_RESET_BIT = 15;
  localparam int LOW_POWER_BIT = 11;
  localparam int LOOPBACK_BIT = 0;
  localparam int TYPE_SEL_W = 6;
  localparam logic [5:0] TYPE_SEL_CODE = 6'h3d;
  localparam logic [15:0] FUSE_KEY_VALUE = 16'h0303;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ATT_RESET_NS = 160;
  localparam int ATT_RESET_CYCLES = (ATT_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : pacd_pkg

// ---- rtl/pacd_reset_pulse.sv ----
// Self-clearing reset pulse for the medium attachment logic.
// Assumes start is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
module pacd_reset_pulse #(
  parameter int CYCLES = pacd_pkg::ATT_RESET_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  output logic busy_r
);
  import pacd_pkg::*;

  localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES + 1) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  typedef enum logic {PACD_IDLE, PACD_HOLD} pacd_pulse_t;

  pacd_pulse_t state_r;
  logic [CNT_W-1:0] cnt_r;

  // A new request while holding restarts the full pulse width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PACD_IDLE;
      cnt_r <= '0;
    end else if (start) begin
      state_r <= PACD_HOLD;
      cnt_r <= '0;
    end else begin
      case (state_r)
        PACD_IDLE: cnt_r <= '0;
        PACD_HOLD: begin
          if (cnt_r == LAST) begin
            state_r <= PACD_IDLE;
          end else begin
            cnt_r <= cnt_r + CNT_W'(1);
          end
        end
        default: state_r <= PACD_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= start || (state_r == PACD_HOLD && cnt_r != LAST);
    end
  end

endmodule : pacd_reset_pulse

// ---- rtl/pacd_fuse_unlock.sv ----
// Fuse supply switch, closed only by writing the unlock key.
// Assumes wr_en is a one-cycle pulse of a full low half-word write to the key register.
`timescale 1ns/1ps
module pacd_fuse_unlock (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [pacd_pkg::REG_W-1:0] wr_data,
  output logic switch_r
);
  import pacd_pkg::*;

  // Once closed the switch stays closed until reset; no key opens it again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      switch_r <= RST_SCAN_STATE[FUSE_SW_BIT];
    end else if (wr_en && wr_data == FUSE_KEY_VALUE) begin
      switch_r <= 1'b1;
    end
  end

endmodule : pacd_fuse_unlock

// ---- sim/pacd_regs_props.sv ----
// Checker for the attachment control and cable diagnostic register bank.
// Assumes it is bound to pacd_regs and sees only that module's ports.
`timescale 1ns/1ps
module pacd_regs_props #(
  parameter int RESET_CYCLES = pacd_pkg::ATT_RESET_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pacd_pkg::ADDR_W-1:0] paddr,
  input wire logic [pacd_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [pacd_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic medium_attachment_reset,
  input wire logic medium_attachment_low_power,
  input wire logic medium_attachment_loopback,
  input wire logic fuse_supply_switch_en
);
  import pacd_pkg::*;
  localparam logic [15:0] A_MET = (IDX_DIAG_METRIC & IDX_PREFIX_MASK) << 2;
  localparam logic [15:0] A_KEY = (IDX_FUSE_KEY & IDX_PREFIX_MASK) << 2;
  localparam logic [15:0] A_CT1 = (IDX_ATT_CTRL1 & IDX_PREFIX_MASK) << 2;
  localparam logic [15:0] A_TYP = (IDX_ATT_TYPE & IDX_PREFIX_MASK) << 2;
  logic wr;
  logic rd;
  logic key_hit;
  logic [7:0] cnt_r;
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;
  assign key_hit = wr && paddr == A_KEY && pstrb[1:0] == 2'b11 && pwdata[15:0] == FUSE_KEY_VALUE;
  // Counts pulse cycles since the last reset write so the pulse length can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 8'h00;
    else if (wr && paddr == A_CT1 && pstrb[1] && pwdata[15]) cnt_r <= 8'h01;
    else if (medium_attachment_reset) cnt_r <= cnt_r + 8'h01;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence rst_wr; wr && paddr == A_CT1 && pstrb[1] && pwdata[15]; endsequence
  sequence hi_wr; wr && paddr == A_CT1 && pstrb[1]; endsequence
  sequence lo_wr; wr && paddr == A_CT1 && pstrb[0]; endsequence
  chk_upper_half_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  chk_metric_low_zero: assert property (rd && paddr == A_MET |-> prdata[3:0] == 4'h0)
    else $error("metric low bits not zero");
  chk_type_code: assert property (rd && paddr == A_TYP |-> prdata == 32'h0000003d)
    else $error("type code wrong");
  chk_fuse_sticky: assert property (fuse_supply_switch_en |=> fuse_supply_switch_en)
    else $error("fuse switch opened");
  chk_fuse_cause: assert property ($rose(fuse_supply_switch_en) |-> $past(key_hit))
    else $error("fuse switch closed without key");
  chk_reset_start: assert property (rst_wr |=> medium_attachment_reset)
    else $error("attachment reset not started");
  chk_reset_length: assert property ($fell(medium_attachment_reset) |-> cnt_r == RESET_CYCLES + 1)
    else $error("attachment reset length wrong");
  chk_low_power_follow: assert property (hi_wr |-> ##3 medium_attachment_low_power == $past(pwdata[11], 3))
    else $error("low power does not follow write");
  chk_loopback_follow: assert property (lo_wr |-> ##3 medium_attachment_loopback == $past(pwdata[0], 3))
    else $error("loopback does not follow write");
endmodule : pacd_regs_props

// ---- sim/tb.sv ----
// Self-checking bench for the attachment control and cable diagnostic registers.
// Assumes pacd_regs alone; the bench is the APB master and drives the diagnostic inputs.
`timescale 1ns/1ps
module tb;
  import pacd_pkg::*;
  // Long enough that a read issued during the pulse still sees it running
  localparam int RC = 8;
  localparam logic [15:0] A_MET = (IDX_DIAG_METRIC & IDX_PREFIX_MASK) << 2;
  localparam logic [15:0] A_STA = (IDX_DIAG_STATE & IDX_PREFIX_MASK) << 2;
  localparam logic [15:0] A_KEY = (IDX_FUSE_KEY & IDX_PREFIX_MASK) << 2;
  localparam logic [15:0] A_SCN = (IDX_SCAN_STATE & IDX_PREFIX_MASK) << 2;
  localparam logic [15:0] A_CT1 = (IDX_ATT_CTRL1 & IDX_PREFIX_MASK) << 2;
  localparam logic [15:0] A_TYP = (IDX_ATT_TYPE & IDX_PREFIX_MASK) << 2;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [11:0] diag_metric = 12'h000;
  logic diag_done = 1'b0;
  logic [10:0] diag_cable_len = 11'h000;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready, pslverr, err, att_rst, att_lp, att_lb, fuse_en;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  pacd_regs #(.RESET_CYCLES(RC)) i_pacd_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .diag_metric(diag_metric), .diag_done(diag_done), .diag_cable_len(diag_cable_len),
    .medium_attachment_reset(att_rst), .medium_attachment_low_power(att_lp),
    .medium_attachment_loopback(att_lb), .fuse_supply_switch_en(fuse_en));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [15:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(what, exp, rdat);
  endtask : rd
  task automatic t_reset_vals;
    rd(A_MET, 32'h0, "metric");
    rd(A_STA, 32'h0, "state");
    rd(A_SCN, 32'h10, "scan");
    rd(A_CT1, 32'h0, "ctrl1");
    rd(A_TYP, 32'h3d, "type");
    apb(1'b0, 16'h0004, 32'h0, 4'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, A_MET + 16'h0001, 32'h0, 4'h0);
    chk("misaligned err", 32'h1, {31'h0, err});
    $display("test reset values done");
  endtask : t_reset_vals
  task automatic t_diag;
    diag_metric <= 12'habc;
    diag_done <= 1'b1;
    diag_cable_len <= 11'h7ff;
    apb(1'b1, A_MET, 32'hffffffff, 4'hf);
    rd(A_MET, 32'h0000abc0, "metric");
    rd(A_STA, 32'h000087ff, "state");
    diag_done <= 1'b0;
    diag_cable_len <= 11'h123;
    repeat (3) @(posedge pclk);
    rd(A_STA, 32'h00000123, "state");
    $display("test diagnostics done");
  endtask : t_diag
  task automatic t_ctrl;
    apb(1'b1, A_CT1, 32'hffff7fff, 4'hf);
    repeat (4) @(posedge pclk);
    chk("low power", 32'h1, {31'h0, att_lp});
    chk("loopback", 32'h1, {31'h0, att_lb});
    rd(A_CT1, 32'h0801, "ctrl1");
    apb(1'b1, A_CT1, 32'h0, 4'h1);
    repeat (4) @(posedge pclk);
    chk("loopback", 32'h0, {31'h0, att_lb});
    rd(A_CT1, 32'h0800, "ctrl1");
    apb(1'b1, A_CT1, 32'h8801, 4'h3);
    @(posedge pclk);
    chk("att reset", 32'h1, {31'h0, att_rst});
    rd(A_CT1, 32'h8801, "ctrl1");
    repeat (RC + 2) @(posedge pclk);
    chk("att reset", 32'h0, {31'h0, att_rst});
    rd(A_CT1, 32'h0801, "ctrl1");
    $display("test attachment control done");
  endtask : t_ctrl
  task automatic t_fuse;
    apb(1'b1, A_SCN, 32'h0008, 4'hf);
    apb(1'b1, A_KEY, 32'h0303, 4'h1);
    apb(1'b1, A_KEY, 32'h0302, 4'hf);
    rd(A_SCN, 32'h10, "scan");
    chk("fuse switch", 32'h0, {31'h0, fuse_en});
    apb(1'b1, A_KEY, 32'h0303, 4'h3);
    @(posedge pclk);
    chk("fuse switch", 32'h1, {31'h0, fuse_en});
    rd(A_SCN, 32'h18, "scan");
    $display("test fuse switch done");
  endtask : t_fuse
  // Only a bus reset may open the fuse switch; it also drops the settings
  task automatic t_mid_reset;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk("fuse switch after reset", 32'h0, {31'h0, fuse_en});
    chk("low power after reset", 32'h0, {31'h0, att_lp});
    chk("loopback after reset", 32'h0, {31'h0, att_lb});
    rd(A_SCN, 32'h10, "scan after reset");
    rd(A_CT1, 32'h0, "ctrl1 after reset");
    $display("test mid-run reset done");
  endtask : t_mid_reset
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  initial begin
    forever #5 pclk = ~pclk;
  end
  // Whole run needs about 120 cycles; the ceiling only catches a hung handshake
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_vals();
    t_diag();
    t_ctrl();
    t_fuse();
    t_mid_reset();
    results();
  end
endmodule : tb
bind pacd_regs pacd_regs_props #(.RESET_CYCLES(RESET_CYCLES)) i_pacd_regs_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .medium_attachment_reset,
  .medium_attachment_low_power, .medium_attachment_loopback, .fuse_supply_switch_en);
